// ---- design/tpo_option_ctrl.sv ----
// timing option control register and shared prescaler routing
`timescale 1ns/1ps
// ==========================================================
// Contract
// - read/write 8-bit register at address 81h
// - bit 7 set disables all port pull-ups
// - bit 6 picks irq edge, 1 rising
// - bit 5 picks timer clock, 1 pin
// - bit 4 set counts falling pin edges
// - bit 3 set gives prescaler to watchdog
// - timer ratio is two to code+1
// - watchdog ratio is two to code
// - one prescaler serves only selected owner
// - prescaler count never software visible
module tpo_option_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire tpo_pkg::tpo_bus_s bus,
  output logic [7:0] rdata,
  output tpo_pkg::tpo_opt_s opt,
  input wire logic [7:0] port_latch,
  output logic [7:0] pullup_en,
  input wire logic ext_irq_pin,
  output logic ext_irq_edge,
  input wire logic timer_ext_clock_pin,
  input wire logic instr_cycle_clock,
  input wire logic watchdog_tick,
  output logic timer_inc,
  output logic watchdog_inc
);
  import tpo_pkg::*;

  // ==========================================================
  // register
  logic [7:0] opt_r;
  logic [7:0] opt_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic sel;

  always_comb begin
    sel = (bus.addr == TPO_OPT_ADDR);
    opt_nxt = opt_r;
    rdata_nxt = 8'h00;
    if (sel && bus.wr) begin
      opt_nxt = bus.wdata;
    end
    // only the option byte is readable
    if (sel && bus.rd) begin
      rdata_nxt = opt_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_r <= TPO_OPT_RESET;
      rdata_r <= 8'h00;
    end else begin
      opt_r <= opt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign opt = tpo_opt_s'(opt_r);

  // ==========================================================
  // pin synchronisers and edge detect
  logic [2:0] irq_s_r;
  logic [2:0] tck_s_r;
  logic [2:0] irq_s_nxt;
  logic [2:0] tck_s_nxt;
  logic irq_edge_nxt;
  logic irq_edge_r;
  logic [7:0] pu_nxt;
  logic [7:0] pu_r;
  logic src_tick;
  logic pre_out;
  logic t_nxt;
  logic w_nxt;
  logic t_r;
  logic w_r;

  always_comb begin
    irq_s_nxt = {irq_s_r[1:0], ext_irq_pin};
    tck_s_nxt = {tck_s_r[1:0], timer_ext_clock_pin};
    // edge chosen by bit 6 on synchronised samples
    if (opt_r[TPO_IRQ_EDGE_BIT]) begin
      irq_edge_nxt = irq_s_r[1] & ~irq_s_r[2];
    end else begin
      irq_edge_nxt = ~irq_s_r[1] & irq_s_r[2];
    end
    // pull-up enables gated by bit 7
    pu_nxt = opt_r[TPO_PULLUP_DIS_BIT] ? 8'h00 : port_latch;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_s_r <= 3'h0;
      tck_s_r <= 3'h0;
      irq_edge_r <= 1'b0;
      pu_r <= 8'h00;
    end else begin
      irq_s_r <= irq_s_nxt;
      tck_s_r <= tck_s_nxt;
      irq_edge_r <= irq_edge_nxt;
      pu_r <= pu_nxt;
    end
  end

  assign ext_irq_edge = irq_edge_r;
  assign pullup_en = pu_r;

  // ==========================================================
  // timer source and prescaler routing
  logic timer_src;
  logic wdt_own;

  always_comb begin
    wdt_own = opt_r[TPO_OWNER_BIT];
    // pin edge select, 1 counts falling
    if (opt_r[TPO_CLK_SRC_BIT]) begin
      timer_src = opt_r[TPO_SRC_EDGE_BIT] ?
        (~tck_s_r[1] & tck_s_r[2]) : (tck_s_r[1] & ~tck_s_r[2]);
    end else begin
      timer_src = instr_cycle_clock;
    end
    // prescaler fed only by its owner
    src_tick = wdt_own ? watchdog_tick : timer_src;
    t_nxt = wdt_own ? timer_src : pre_out;
    w_nxt = wdt_own ? pre_out : watchdog_tick;
  end

  tpo_prescaler #(
    .W(TPO_PRE_W)
  ) u_pre (
    .clk(clk),
    .rst(rst),
    .tick(src_tick),
    .rate_code(opt_r[TPO_RATE_LSB +: TPO_RATE_W]),
    .wdt_owner(wdt_own),
    .out_pulse(pre_out)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t_r <= 1'b0;
      w_r <= 1'b0;
    end else begin
      t_r <= t_nxt;
      w_r <= w_nxt;
    end
  end

  assign timer_inc = t_r;
  assign watchdog_inc = w_r;

  // ==========================================================
  // checks
  opt_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == TPO_OPT_ADDR) |=> (opt_r == $past(bus.wdata)))
    else $error("option write not stored");
  opt_read_a: assert property (
    @(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == TPO_OPT_ADDR && !bus.wr) |=> (rdata == opt_r))
    else $error("option read wrong");
  pullup_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    $past(opt_r[7]) |-> (pullup_en == 8'h00))
    else $error("pull-ups not disabled");
  irq_rise_a: assert property (
    @(posedge clk) disable iff (rst)
    (opt_r[6] && $past(opt_r[6]) && irq_s_r[2] && !irq_s_r[1])
      |=> !ext_irq_edge)
    else $error("falling edge raised irq in rising mode");
  int_src_a: assert property (
    @(posedge clk) disable iff (rst)
    (!opt_r[5] && opt_r[3] && instr_cycle_clock) |=> timer_inc)
    else $error("internal clock not routed");
  wdt_pass_a: assert property (
    @(posedge clk) disable iff (rst)
    (!opt_r[3] && watchdog_tick) |=> watchdog_inc)
    else $error("watchdog tick lost while timer owns prescaler");
  no_read_other_a: assert property (
    @(posedge clk) disable iff (rst)
    (bus.addr != TPO_OPT_ADDR) |=> (rdata == 8'h00))
    else $error("unmapped read returned data");
  reset_ones_a: assert property (
    @(posedge clk) $fell(rst) |-> (opt_r == 8'hFF || $past(bus.wr)))
    else $error("option not all ones after reset");
endmodule

// ---- design/tpo_pkg.sv ----
// package: register map, field layout and codes for timing option control
package tpo_pkg;
  localparam logic [7:0] TPO_OPT_ADDR = 8'h81;
  localparam logic [7:0] TPO_OPT_RESET = 8'hFF;
  localparam int TPO_PULLUP_DIS_BIT = 7;
  localparam int TPO_IRQ_EDGE_BIT = 6;
  localparam int TPO_CLK_SRC_BIT = 5;
  localparam int TPO_SRC_EDGE_BIT = 4;
  localparam int TPO_OWNER_BIT = 3;
  localparam int TPO_RATE_LSB = 0;
  localparam int TPO_RATE_W = 3;
  localparam int TPO_PRE_W = 8;

  // decoded option fields as seen by timer, watchdog, port and irq logic
  typedef struct packed {
    logic pullup_disable;
    logic ext_irq_edge_select;
    logic timer_clock_source;
    logic timer_source_edge;
    logic prescaler_owner_select;
    logic [2:0] prescale_rate_code;
  } tpo_opt_s;

  // data-space access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tpo_bus_s;
endpackage

// ---- design/tpo_prescaler.sv ----
// shared prescaler: divides one selected source by the chosen ratio
`timescale 1ns/1ps
module tpo_prescaler #(
  parameter int W = tpo_pkg::TPO_PRE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [2:0] rate_code,
  input wire logic wdt_owner,
  output logic out_pulse
);
  import tpo_pkg::*;

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic [3:0] shift;
  logic [W-1:0] mask;

  // ratio 2^code for watchdog, 2^(code+1) for timer
  always_comb begin
    shift = {1'b0, rate_code} + {3'h0, ~wdt_owner};
    mask = W'((9'h001 << shift) - 9'h001);
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (tick) begin
      if ((cnt_r & mask) == mask) begin
        cnt_nxt = '0;
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign out_pulse = out_r;
endmodule

// ---- verification/timer_prescaler_option_control_test.sv ----
// self-checking bench for the timing option control register block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module timer_prescaler_option_control_test;
  import tpo_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic clk = 1'b0;
  logic rst = 1'b1;
  tpo_bus_s bus = '0;
  logic [7:0] port_latch = 8'h3C;
  logic irq_pin = 1'b0;
  logic tpin = 1'b0;
  logic itick = 1'b1;
  logic wtick = 1'b1;
  logic [7:0] rdata;
  logic [7:0] pullup_en;
  tpo_opt_s opt;
  logic ext_irq_edge;
  logic timer_inc;
  logic watchdog_inc;
  int errors = 0;
  int n_compared = 0;
  int nt;
  int nw;
  int ni;

  always #5 clk = ~clk;

  // watchdog ticks at half rate so the two prescaler sources differ
  always @(posedge clk) wtick <= ~wtick;

  tpo_option_ctrl DUT (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .opt(opt), .port_latch(port_latch), .pullup_en(pullup_en),
    .ext_irq_pin(irq_pin), .ext_irq_edge(ext_irq_edge),
    .timer_ext_clock_pin(tpin), .instr_cycle_clock(itick),
    .watchdog_tick(wtick), .timer_inc(timer_inc),
    .watchdog_inc(watchdog_inc));

  // ==========================================================
  // access tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  // counts output pulses over n cycles; phase of the prescaler is unknown
  task automatic run(input int n);
    nt = 0;
    nw = 0;
    ni = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      nt += int'(timer_inc === 1'b1);
      nw += int'(watchdog_inc === 1'b1);
      ni += int'(ext_irq_edge === 1'b1);
    end
  endtask

  // one count of slack covers the unknown prescaler phase at window edges
  function automatic logic near(input int n, input int e);
    return (n >= e - 1) && (n <= e + 1);
  endfunction

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("opt_reset", TPO_OPT_RESET, opt)
    rd_chk(TPO_OPT_ADDR, 8'hFF);
    wr(TPO_OPT_ADDR, 8'h5A);
    rd_chk(TPO_OPT_ADDR, 8'h5A);
    wr(TPO_OPT_ADDR, 8'hA5);
    wr(8'h80, 8'h00);
    wr(8'h01, 8'h00);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h82, 8'h00);
    rd_chk(TPO_OPT_ADDR, 8'hA5);
    `CHK("opt_fields", 8'hA5, opt)
    $display("access test done");
    wr(TPO_OPT_ADDR, 8'h7F);
    run(3);
    `CHK("pullup_on", 8'h3C, pullup_en)
    @(posedge clk);
    port_latch <= 8'hC3;
    run(3);
    `CHK("pullup_latch", 8'hC3, pullup_en)
    wr(TPO_OPT_ADDR, 8'hFF);
    run(3);
    `CHK("pullup_off", 8'h00, pullup_en)
    $display("pull-up test done");
    for (int o = 0; o < 2; o++) begin
      for (int c = 0; c < 8; c++) begin
        wr(TPO_OPT_ADDR, {4'h0, o[0], c[2:0]});
        run(8);
        run(512);
        `CHK("timer_rate", 1'b1, near(nt, o ? 512 : 512 >> (c + 1)))
        `CHK("wdog_rate", 1'b1, near(nw, o ? 256 >> c : 256))
        if (o == 1) `CHK("timer_unscaled", 512, nt)
      end
    end
    $display("prescaler test done");
    for (int e = 0; e < 2; e++) begin
      wr(TPO_OPT_ADDR, {1'b0, e[0], 1'b1, e[0], 4'h8});
      run(10);
      @(posedge clk);
      tpin <= 1'b1;
      irq_pin <= 1'b1;
      run(12);
      `CHK("rise_timer", 1 - e, nt)
      `CHK("rise_irq", e, ni)
      @(posedge clk);
      tpin <= 1'b0;
      irq_pin <= 1'b0;
      run(12);
      `CHK("fall_timer", e, nt)
      `CHK("fall_irq", 1 - e, ni)
    end
    $display("pin edge test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run(1);
    `CHK("opt_rereset", 8'hFF, opt)
    $display("second reset test done");
    final_report;
  end

  // bench needs about 8500 cycles; cut off at 20000 cycles, over twice that
  initial begin
    #200_000;
    errors++;
    $display("watchdog expired before the tests ended");
    final_report;
  end
endmodule
